// ---- hdl/sori_consts.svh ----
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Device offsets are 10-bit byte addresses on the register port
// Notes: Controller offsets are AHB-Lite byte addresses, one word each
`ifndef SORI_CONSTS_SVH
`define SORI_CONSTS_SVH

// Device register offsets
`define SORI_ADDR_SYNC 10'h210
`define SORI_ADDR_LEVEL 10'h211
`define SORI_ADDR_OVRCTL 10'h213
`define SORI_ADDR_START 10'h270
`define SORI_ADDR_PWR2 10'h29a

// Device reset values and implemented-bit masks
`define SORI_RST_SYNC 5'h03
`define SORI_RST_LEVEL 8'hf2
`define SORI_RST_STRETCH 3'h7
`define SORI_RST_PINEN 1'h0
`define SORI_RST_PWR2 8'h0f
`define SORI_MASK_SYNC 8'h1f
`define SORI_MASK_OVRCTL 8'h0f
`define SORI_MASK_FULL 8'hff
`define SORI_OVRCTL_EN_BIT 3

// Power-mode codes
`define SORI_PWR_LOW 8'h06
`define SORI_PWR_HIGH 8'h0f

// Over-range pulse: base length in sampling cycles, counter width
`define SORI_STRETCH_BASE 10'h004
`define SORI_STRETCH_W 10

// Cycles until the device reports its initialization finished
`define SORI_INIT_CYCLES 64

// Controller register offsets
`define SORI_H_DEVADDR 8'h00
`define SORI_H_WDATA 8'h04
`define SORI_H_CMD 8'h08
`define SORI_H_STATUS 8'h0c
`define SORI_H_RDATA 8'h10
`define SORI_H_LINK 8'h14

`endif

// ---- hdl/sori_dev.sv ----
// Purpose: Device end: register bank, SYNC~ request filter, over-range pins
// Assumes: One sample per channel per core_clk; link clock is every second edge
// Notes: Register port answers one cycle after each request
//
// Summary of operation
// - Request after threshold plus one consecutive lows
// - SYNC~ sampled on half-rate link ticks
// - Shorter low pulses ignored as error reports
// - Threshold changed only with link disabled
// - Receiver sends no error pulses, threshold zero
// - Pin asserts when level reaches threshold
// - Pins held low unless enable bit set
// - Pulse lasts four times two-power field
// - Init bit reads one once setup done
// - No access before init bit reads one
// - Reserved fields written with default only
// - Power mode holds 0x06 or 0x0f only
// - Link off before power-mode change
`default_nettype none
`include "sori_consts.svh"
module sori_dev (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Link to the controller
    sori_if.dev link,
    // Converter samples
    input wire sori_pkg::sori_samples_t samples,
    // Status outputs
    output logic sync_request,
    output logic overrange_out_a,
    output logic overrange_out_b,
    output logic overrange_out_c,
    output logic overrange_out_d,
    output logic init_done,
    output logic [7:0] power_mode_code_second
);
    import sori_pkg::*;

    localparam int INIT_W = $clog2(`SORI_INIT_CYCLES + 1);

    // Magnitude of a sample reduced to the 8-bit threshold scale
    function automatic logic [7:0] level_of(input logic [11:0] s);
        logic [11:0] mag;
        mag = s[11] ? 12'(~s + 12'h001) : s;
        if (mag[11]) begin
            mag = 12'h7ff;
        end
        return mag[10:3];
    endfunction : level_of

    // Pulse length minus one for a given stretch field
    function automatic logic [`SORI_STRETCH_W-1:0] stretch_len(input logic [2:0] n);
        return `SORI_STRETCH_W'((`SORI_STRETCH_BASE << n) - 10'h001);
    endfunction : stretch_len

    logic [4:0] sync_request_count_ff;
    logic [7:0] overrange_level_field_ff;
    logic overrange_pin_enable_ff;
    logic [2:0] overrange_pulse_stretch_ff;
    logic [7:0] power_mode_code_second_ff;
    logic [INIT_W-1:0] init_cnt_ff;
    logic init_done_ff;
    logic ack_ff;
    logic [7:0] rdata_ff;
    logic [7:0] rd_val;
    logic link_tick_ff;
    logic [5:0] low_cnt_ff;
    logic [5:0] nxt_low_cnt;
    logic sync_request_ff;
    logic [3:0] ovr_ff;
    logic [`SORI_STRETCH_W-1:0] stretch_cnt_ff [4];
    logic [3:0] hit;
    logic wr_take;

    assign wr_take = link.req & link.wr;

    // Initialization sequence after reset
    always_ff @(posedge core_clk) begin : init_seq
        if (!rstn) begin
            init_cnt_ff <= '0;
            init_done_ff <= 1'b0;
        end else if (!init_done_ff) begin
            init_cnt_ff <= INIT_W'(init_cnt_ff + 1'b1);
            init_done_ff <= (init_cnt_ff == INIT_W'(`SORI_INIT_CYCLES - 1));
        end
    end

    // Writable configuration; reserved bits are not stored
    always_ff @(posedge core_clk) begin : cfg_regs
        if (!rstn) begin
            sync_request_count_ff <= `SORI_RST_SYNC;
            overrange_level_field_ff <= `SORI_RST_LEVEL;
            overrange_pin_enable_ff <= `SORI_RST_PINEN;
            overrange_pulse_stretch_ff <= `SORI_RST_STRETCH;
            power_mode_code_second_ff <= `SORI_RST_PWR2;
        end else if (wr_take) begin
            case (link.addr)
                `SORI_ADDR_SYNC: begin
                    sync_request_count_ff <= link.wdata[4:0];
                end
                `SORI_ADDR_LEVEL: begin
                    overrange_level_field_ff <= link.wdata;
                end
                `SORI_ADDR_OVRCTL: begin
                    overrange_pin_enable_ff <= link.wdata[`SORI_OVRCTL_EN_BIT];
                    overrange_pulse_stretch_ff <= link.wdata[2:0];
                end
                `SORI_ADDR_PWR2: begin
                    power_mode_code_second_ff <= link.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin : rd_mux
        rd_val = 8'h00;
        case (link.addr)
            `SORI_ADDR_SYNC: begin
                rd_val = {3'h0, sync_request_count_ff};
            end
            `SORI_ADDR_LEVEL: begin
                rd_val = overrange_level_field_ff;
            end
            `SORI_ADDR_OVRCTL: begin
                rd_val = {4'h0, overrange_pin_enable_ff, overrange_pulse_stretch_ff};
            end
            `SORI_ADDR_START: begin
                rd_val = {7'h00, init_done_ff};
            end
            `SORI_ADDR_PWR2: begin
                rd_val = power_mode_code_second_ff;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // Answer every request one cycle later
    always_ff @(posedge core_clk) begin : reg_answer
        if (!rstn) begin
            ack_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= link.req;
            if (link.req && !link.wr) begin
                rdata_ff <= rd_val;
            end
        end
    end

    // Link clock tick at half the sample rate
    always_ff @(posedge core_clk) begin : link_tick
        if (!rstn) begin
            link_tick_ff <= 1'b0;
        end else begin
            link_tick_ff <= !link_tick_ff;
        end
    end

    assign nxt_low_cnt = (low_cnt_ff == 6'h3f) ? low_cnt_ff : 6'(low_cnt_ff + 6'h01);

    // SYNC~ filter: consecutive low samples counted on link ticks
    always_ff @(posedge core_clk) begin : sync_filter
        if (!rstn || !link.link_en) begin
            low_cnt_ff <= 6'h00;
            sync_request_ff <= 1'b0;
        end else if (link_tick_ff) begin
            if (link.sync_n) begin
                // A short low ends here without effect
                low_cnt_ff <= 6'h00;
                sync_request_ff <= 1'b0;
            end else begin
                low_cnt_ff <= nxt_low_cnt;
                sync_request_ff <= (nxt_low_cnt > {1'b0, sync_request_count_ff});
            end
        end
    end

    // Per-channel threshold compare
    always_comb begin : ovr_compare
        hit = 4'h0;
        for (int ch = 0; ch < 4; ch++) begin
            hit[ch] = (level_of(samples[ch]) >= overrange_level_field_ff);
        end
    end

    // Over-range pulse stretch, one counter per channel
    always_ff @(posedge core_clk) begin : ovr_stretch
        if (!rstn) begin
            ovr_ff <= 4'h0;
            for (int ch = 0; ch < 4; ch++) begin
                stretch_cnt_ff[ch] <= '0;
            end
        end else begin
            for (int ch = 0; ch < 4; ch++) begin
                if (!overrange_pin_enable_ff) begin
                    ovr_ff[ch] <= 1'b0;
                    stretch_cnt_ff[ch] <= '0;
                end else if (hit[ch]) begin
                    ovr_ff[ch] <= 1'b1;
                    stretch_cnt_ff[ch] <= stretch_len(overrange_pulse_stretch_ff);
                end else if (stretch_cnt_ff[ch] != '0) begin
                    ovr_ff[ch] <= 1'b1;
                    stretch_cnt_ff[ch] <= `SORI_STRETCH_W'(stretch_cnt_ff[ch] - 1'b1);
                end else begin
                    ovr_ff[ch] <= 1'b0;
                end
            end
        end
    end

    assign link.ack = ack_ff;
    assign link.rdata = rdata_ff;
    assign sync_request = sync_request_ff;
    assign overrange_out_a = ovr_ff[0];
    assign overrange_out_b = ovr_ff[1];
    assign overrange_out_c = ovr_ff[2];
    assign overrange_out_d = ovr_ff[3];
    assign init_done = init_done_ff;
    assign power_mode_code_second = power_mode_code_second_ff;

endmodule : sori_dev
`default_nettype wire

// ---- hdl/sori_host.sv ----
// Purpose: Controller end: AHB-Lite registers driving the device register port
// Assumes: One AHB-Lite master, single word transfers, same clock as device
// Notes: Reads take one wait state, writes none
`default_nettype none
`include "sori_consts.svh"
module sori_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Link to the device
    sori_if.host link
);
    import sori_pkg::*;

    // Implemented-bit mask of a device register
    function automatic logic [7:0] field_mask(input logic [9:0] a);
        case (a)
            `SORI_ADDR_SYNC: field_mask = `SORI_MASK_SYNC;
            `SORI_ADDR_OVRCTL: field_mask = `SORI_MASK_OVRCTL;
            default: field_mask = `SORI_MASK_FULL;
        endcase
    endfunction : field_mask

    sori_hstate_e state_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic rd_pend_ff;
    logic [7:0] haddr_ff;
    logic [9:0] dev_addr_ff;
    logic [7:0] dev_wdata_ff;
    logic [7:0] dev_rdata_ff;
    logic init_seen_ff;
    logic refused_ff;
    logic link_en_ff;
    logic sync_drive_ff;
    logic req_ff;
    logic wr_ff;
    logic [9:0] addr_ff;
    logic [7:0] wdata_ff;
    logic take;
    logic go;
    logic bad;
    logic set_ref;
    logic clr_ref;

    assign take = hsel & htrans[1] & hready;
    assign go = wr_pend_ff && (haddr_ff == `SORI_H_CMD) && hwdata[0];
    assign clr_ref = wr_pend_ff && (haddr_ff == `SORI_H_STATUS) && hwdata[2];

    // Orders the device must not receive
    always_comb begin : refuse_chk
        bad = !init_seen_ff || (state_ff != HS_IDLE);
        if (hwdata[1] && dev_addr_ff == `SORI_ADDR_SYNC && link_en_ff) begin
            bad = 1'b1;
        end
        if (hwdata[1] && dev_addr_ff == `SORI_ADDR_PWR2) begin
            if (link_en_ff) begin
                bad = 1'b1;
            end
            if (dev_wdata_ff != `SORI_PWR_LOW && dev_wdata_ff != `SORI_PWR_HIGH) begin
                bad = 1'b1;
            end
        end
    end

    assign set_ref = go & bad;

    // AHB address phase capture and wait state for reads
    always_ff @(posedge core_clk) begin : ahb_phase
        if (!rstn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            haddr_ff <= 8'h00;
            hreadyout_ff <= 1'b1;
        end else begin
            wr_pend_ff <= take & hwrite;
            rd_pend_ff <= take & !hwrite;
            if (take) begin
                haddr_ff <= haddr[7:0];
            end
            hreadyout_ff <= !(take & !hwrite);
        end
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge core_clk) begin : ahb_read
        if (!rstn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_pend_ff) begin
            case (haddr_ff)
                `SORI_H_DEVADDR: hrdata_ff <= {22'h0, dev_addr_ff};
                `SORI_H_WDATA: hrdata_ff <= {24'h0, dev_wdata_ff};
                `SORI_H_STATUS: hrdata_ff <= {29'h0, refused_ff, init_seen_ff,
                    state_ff != HS_IDLE};
                `SORI_H_RDATA: hrdata_ff <= {24'h0, dev_rdata_ff};
                `SORI_H_LINK: hrdata_ff <= {30'h0, sync_drive_ff, link_en_ff};
                default: hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Software-written controller registers
    always_ff @(posedge core_clk) begin : ahb_write
        if (!rstn) begin
            dev_addr_ff <= 10'h000;
            dev_wdata_ff <= 8'h00;
            link_en_ff <= 1'b0;
            sync_drive_ff <= 1'b0;
        end else if (wr_pend_ff) begin
            case (haddr_ff)
                `SORI_H_DEVADDR: dev_addr_ff <= hwdata[9:0];
                `SORI_H_WDATA: dev_wdata_ff <= hwdata[7:0];
                `SORI_H_LINK: begin
                    link_en_ff <= hwdata[0];
                    sync_drive_ff <= hwdata[1];
                end
                default: begin
                end
            endcase
        end
    end

    // Refused flag: a new refusal wins over a clear
    always_ff @(posedge core_clk) begin : refuse_flag
        if (!rstn) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= set_ref | (refused_ff & !clr_ref);
        end
    end

    // Sequencer: wait for init, then run one order at a time
    always_ff @(posedge core_clk) begin : seq
        if (!rstn) begin
            state_ff <= HS_POLL;
            init_seen_ff <= 1'b0;
            req_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 10'h000;
            wdata_ff <= 8'h00;
            dev_rdata_ff <= 8'h00;
        end else begin
            req_ff <= 1'b0;
            case (state_ff)
                HS_POLL: begin
                    req_ff <= 1'b1;
                    wr_ff <= 1'b0;
                    addr_ff <= `SORI_ADDR_START;
                    state_ff <= HS_POLL_WAIT;
                end
                HS_POLL_WAIT: begin
                    if (link.ack) begin
                        init_seen_ff <= link.rdata[0];
                        state_ff <= link.rdata[0] ? HS_IDLE : HS_POLL;
                    end
                end
                HS_IDLE: begin
                    if (go && !bad) begin
                        req_ff <= 1'b1;
                        wr_ff <= hwdata[1];
                        addr_ff <= dev_addr_ff;
                        wdata_ff <= dev_wdata_ff & field_mask(dev_addr_ff);
                        state_ff <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (link.ack) begin
                        if (!wr_ff) begin
                            dev_rdata_ff <= link.rdata;
                        end
                        state_ff <= HS_IDLE;
                    end
                end
                default: begin
                    state_ff <= HS_POLL;
                end
            endcase
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign link.req = req_ff;
    assign link.wr = wr_ff;
    assign link.addr = addr_ff;
    assign link.wdata = wdata_ff;
    assign link.link_en = link_en_ff;
    // SYNC~ held low as a level for as long as sync_drive_ff is set, however short
    assign link.sync_n = !sync_drive_ff;

endmodule : sori_host
`default_nettype wire

// ---- hdl/sori_if.sv ----
// Purpose: Register port, SYNC~ and link enable between controller and device
// Assumes: Both ends run on the same core_clk
// Notes: req is a one-cycle pulse; ack answers it one cycle later
`default_nettype none
interface sori_if;
    logic req;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic sync_n;
    logic link_en;
    modport dev (
        input req, wr, addr, wdata, sync_n, link_en,
        output rdata, ack
    );
    modport host (
        output req, wr, addr, wdata, sync_n, link_en,
        input rdata, ack
    );
endinterface : sori_if
`default_nettype wire

// ---- hdl/sori_pkg.sv ----
// Purpose: Types shared by both ends
// Assumes: Four channels of 12-bit two's complement samples
// Notes: Constants live in sori_consts.svh
`default_nettype none
package sori_pkg;
    typedef logic [3:0][11:0] sori_samples_t;
    typedef logic [9:0] sori_addr_t;
    typedef enum logic [1:0] {
        HS_POLL,
        HS_POLL_WAIT,
        HS_IDLE,
        HS_WAIT
    } sori_hstate_e;
endpackage : sori_pkg
`default_nettype wire

// ---- tb/sori_properties.sv ----
// Purpose: Checks the register port and link enable line between the two ends
// Assumes: One clock domain, synchronous active-low reset
// Notes: Sees the interface signals only
`default_nettype none
`include "sori_consts.svh"
module sori_properties (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic req,
    input wire logic wr,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    // Link control
    input wire logic sync_n,
    input wire logic link_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_ff;
    logic nxt_seen;
    logic [9:0] rd_addr_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Set once a read of the startup state has come back finished
    assign nxt_seen = seen_ff | (ack && rd_addr_ff == `SORI_ADDR_START && rdata[0]);

    always_ff @(posedge core_clk) begin
        if (!rstn) seen_ff <= 1'b0;
        else seen_ff <= nxt_seen;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) rd_addr_ff <= '0;
        else if (req && !wr) rd_addr_ff <= addr;
    end

    sequence s_answer;
        ##1 ack;
    endsequence

    sequence s_dev_write(logic [9:0] a);
        req && wr && addr == a;
    endsequence

    chk_ack_timely: assert property (req |-> s_answer)
        else $error("ack missing one cycle after request");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without a request");
    chk_thr_link_off: assert property (s_dev_write(`SORI_ADDR_SYNC) |-> !link_en)
        else $error("threshold written with link enabled");
    chk_pwr_link_off: assert property (s_dev_write(`SORI_ADDR_PWR2) |-> !link_en)
        else $error("power mode written with link enabled");
    chk_pwr_code: assert property (s_dev_write(`SORI_ADDR_PWR2) |->
        (wdata == `SORI_PWR_LOW || wdata == `SORI_PWR_HIGH))
        else $error("reserved power mode code written");
    chk_reserved_clean: assert property (req && wr |->
        (addr != `SORI_ADDR_SYNC || wdata[7:5] == 3'h0) &&
        (addr != `SORI_ADDR_OVRCTL || wdata[7:4] == 4'h0))
        else $error("reserved bits written nonzero");
    chk_init_first: assert property (req && !seen_ff |-> !wr && addr == `SORI_ADDR_START)
        else $error("access before initialization finished");
    chk_init_bits: assert property (ack && rd_addr_ff == `SORI_ADDR_START |->
        rdata[7:1] == 7'h00)
        else $error("startup state reserved bits nonzero");
endmodule : sori_properties
`default_nettype wire

// ---- tb/tb_sync_overrange_init_regs.sv ----
// Purpose: Drives both ends over AHB-Lite and compares with a register model
// Assumes: Controller and device share core_clk at 50 MHz
// Notes: Device accesses go through the controller order registers
`default_nettype none
`include "sori_consts.svh"
module tb_sync_overrange_init_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import sori_pkg::*;
    logic core_clk;
    logic rstn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    sori_samples_t samples;
    logic sync_request;
    logic [3:0] ovr;
    logic init_done;
    logic [7:0] pwr;
    logic [31:0] rv;
    logic sync_seen;
    int n_errors;
    int n_tests;
    int seed;
    int link_on;
    int k;
    int model[int];
    int regs[6] = '{'h210, 'h211, 'h213, 'h270, 'h29a, 'h3ff};

    sori_if link_if ();
    sori_dev u_sori_dev (.core_clk(core_clk), .rstn(rstn), .link(link_if), .samples(samples),
        .sync_request(sync_request), .overrange_out_a(ovr[0]), .overrange_out_b(ovr[1]),
        .overrange_out_c(ovr[2]), .overrange_out_d(ovr[3]), .init_done(init_done),
        .power_mode_code_second(pwr));
    sori_host u_sori_host (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_if));
    sori_properties u_sori_properties (.core_clk(core_clk), .rstn(rstn), .req(link_if.req),
        .wr(link_if.wr), .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata),
        .ack(link_if.ack), .sync_n(link_if.sync_n), .link_en(link_if.link_en));

    always #10 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (sync_request === 1'b1) sync_seen <= 1'b1;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_up(input string what);
        n_errors++;
        $display("BAD %s expected completion seen timeout", what);
        report_and_stop();
    endtask : give_up

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) give_up("hready");
    endtask : wait_ready

    // One AHB-Lite single transfer; read data lands in rv
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rv = hrdata;
        check("hresp", hresp, 1'b0);
    endtask : ahb

    task automatic dev_op(input logic w, input int a, input int d);
        int n;
        ahb(1'b1, `SORI_H_DEVADDR, a);
        ahb(1'b1, `SORI_H_WDATA, d);
        ahb(1'b1, `SORI_H_CMD, {w, 1'b1});
        n = 0;
        do begin
            ahb(1'b0, `SORI_H_STATUS, 0);
            n++;
        end while (rv[0] !== 1'b0 && n < 20);
        if (n >= 20) give_up("busy");
        ahb(1'b0, `SORI_H_RDATA, 0);
    endtask : dev_op

    task automatic dev_rd(input int a);
        dev_op(1'b0, a, 0);
        check("device read", rv, model.exists(a) ? model[a] : 0);
    endtask : dev_rd

    // Model of acceptance: masked data, link lock-out and legal power codes
    task automatic dev_wr(input int a, input int d);
        int m;
        logic bad;
        m = d & (a == 'h210 ? 'h1f : a == 'h213 ? 'h0f : 'hff);
        bad = (link_on != 0 && (a == 'h210 || a == 'h29a)) || (a == 'h29a && m != 6 && m != 'hf);
        if (!bad) model[a] = m;
        dev_op(1'b1, a, d);
        ahb(1'b0, `SORI_H_WDATA, 0);
        check("wdata", rv, d & 'hff);
        ahb(1'b0, `SORI_H_STATUS, 0);
        check("refused", rv[2], bad);
        ahb(1'b1, `SORI_H_STATUS, 4);
        dev_rd(a);
    endtask : dev_wr

    task automatic set_link(input int v);
        ahb(1'b1, `SORI_H_LINK, v);
        link_on = v & 1;
    endtask : set_link

    task automatic sync_test(input int thr);
        int n;
        dev_wr('h210, thr);
        set_link(3);
        n = 0;
        while (sync_request !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 200) give_up("sync request");
        check("sync delay", n >= 2 * thr + 2 && n <= 2 * thr + 4, 1'b1);
        set_link(0);
    endtask : sync_test

    // One hit cycle on channel c, other channels random below the level
    task automatic pulse(input int c, input logic [11:0] v);
        sori_samples_t t;
        for (int i = 0; i < 4; i++) t[i] = 12'($random(seed) % 1000);
        t[c] = v;
        samples <= t;
        @(posedge core_clk);
        samples <= '0;
    endtask : pulse

    task automatic stretch_test(input int c, input int s, input logic [11:0] v);
        int n;
        logic [3:0] other;
        pulse(c, v);
        n = 0;
        while (ovr[c] !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 10) give_up("ovr rise");
        check("ovr rise", n < 10, 1'b1);
        n = 0;
        other = 4'h0;
        while (ovr[c] === 1'b1 && n < 1200) begin
            other = other | (ovr & ~(4'h1 << c));
            @(posedge core_clk);
            n++;
        end
        if (n >= 1200) give_up("ovr length");
        check("ovr length", n >= (4 << s) && n <= (4 << s) + 2, 1'b1);
        check("ovr other", other, 4'h0);
    endtask : stretch_test

    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        samples = '0;
        seed = 88642;
        link_on = 0;
        sync_seen = 1'b0;
        model = '{'h210: 'h03, 'h211: 'hf2, 'h213: 'h07, 'h29a: 'h0f};
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        check("pwr reset", pwr, 8'h0f);
        check("ovr reset", ovr, 4'h0);
        ahb(1'b1, `SORI_H_CMD, 1);
        ahb(1'b0, `SORI_H_STATUS, 0);
        check("early order", rv[2], 1'b1);
        check("early init", init_done, 1'b0);
        ahb(1'b1, `SORI_H_STATUS, 4);
        k = 0;
        do begin
            ahb(1'b0, `SORI_H_STATUS, 0);
            k++;
        end while (rv[1] !== 1'b1 && k < 100);
        if (k >= 100) give_up("init");
        check("init done", init_done, 1'b1);
        model['h270] = 1;
        foreach (regs[i]) dev_rd(regs[i]);
        ahb(1'b0, 'h18, 0);
        check("unmapped", rv, 0);
        ahb(1'b0, `SORI_H_DEVADDR, 0);
        check("devaddr", rv, 'h3ff);
        set_link(1);
        ahb(1'b0, `SORI_H_LINK, 0);
        check("link", rv, 1);
        dev_wr('h210, 'h00);
        dev_wr('h29a, 'h06);
        set_link(0);
        dev_wr('h210, 'hff);
        dev_wr('h29a, 'h06);
        check("pwr low", pwr, 8'h06);
        dev_wr('h29a, 'h33);
        dev_wr('h29a, 'h0f);
        foreach (regs[i]) if (i < 3) sync_test(i * 14 + i / 2 * 3);
        dev_wr('h210, 1);
        set_link(1);
        sync_seen = 1'b0;
        ahb(1'b1, `SORI_H_LINK, 3);
        ahb(1'b1, `SORI_H_LINK, 1);
        repeat (10) @(posedge core_clk);
        check("short low", sync_seen, 1'b0);
        set_link(0);
        dev_wr('h210, 0);
        dev_wr('h211, 'h80);
        dev_wr('h213, 'hf7);
        pulse(0, 12'h7ff);
        repeat (6) @(posedge core_clk);
        check("ovr disabled", ovr, 4'h0);
        for (int s = 0; s < 8; s++) begin
            dev_wr('h213, 8 | s);
            stretch_test(s % 4, s, s[0] ? 12'hc00 : 12'h400);
            pulse(s % 4, s[0] ? 12'hc08 : 12'h3f8);
            repeat (6) @(posedge core_clk);
            check("ovr below", ovr, 4'h0);
        end
        report_and_stop();
    end
endmodule : tb_sync_overrange_init_regs
`default_nettype wire
